// File: logic/mtm_pkg.sv
// Constants and types of the measurement threshold monitor.
// Assumes one 10 MHz clock and a 32-bit AXI4-Lite register bus.
package mtm_pkg;

    // ************************************************************
    // Register map: word index, byte address is four times it
    // ************************************************************
    localparam int         MTM_ADDR_W      = 8;
    localparam logic [5:0] MTM_IDX_TEMP_UP = 6'h06;
    localparam logic [5:0] MTM_IDX_TEMP_LO = 6'h07;
    localparam logic [5:0] MTM_IDX_AUX_INPUT_ONE_UP = 6'h08;
    localparam logic [5:0] MTM_IDX_AUX_INPUT_ONE_LO = 6'h09;
    localparam logic [5:0] MTM_IDX_AUX_INPUT_TWO_UP = 6'h0a;
    localparam logic [5:0] MTM_IDX_AUX_INPUT_TWO_LO = 6'h0b;
    localparam logic [5:0] MTM_IDX_CFG     = 6'h0c;
    localparam logic [5:0] MTM_IDX_IST     = 6'h10;
    localparam logic [5:0] MTM_IDX_IMASK   = 6'h11;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int          MTM_NUM_LIM    = 6;
    localparam int          MTM_EN_BIT     = 12;
    localparam logic [12:0] MTM_UP_RST     = 13'h0fff;
    localparam logic [12:0] MTM_LO_RST     = 13'h0000;
    localparam int          MTM_CFG_SRC    = 15;
    localparam int          MTM_CFG_PIN    = 9;
    localparam int          MTM_CFG_FLG_HI = 8;
    localparam int          MTM_CFG_FLG_LO = 3;
    localparam logic [1:0]  MTM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  MTM_RESP_SLV   = 2'h2;

    // Scan-mode codes that select a temperature input
    localparam logic [3:0]  MTM_SCAN_TEMP_INPUT_FIRST = 4'h1;
    localparam logic [3:0]  MTM_SCAN_TEMP_INPUT_SECOND = 4'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MTM_CH_TEMP_INPUT_FIRST = 2'h0,
        MTM_CH_TEMP_INPUT_SECOND = 2'h1,
        MTM_CH_AUX_INPUT_ONE  = 2'h2,
        MTM_CH_AUX_INPUT_TWO  = 2'h3
    } mtm_chan_t;

    typedef enum logic [2:0] {
        MTM_BS_IDLE  = 3'b001,
        MTM_BS_BRESP = 3'b010,
        MTM_BS_RRESP = 3'b100
    } mtm_bus_st_t;

    typedef struct packed {
        logic        valid;
        mtm_chan_t   chan;
        logic [11:0] data;
    } mtm_result_t;

    typedef struct packed {
        mtm_bus_st_t      st;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       waddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic [1:0]       bresp;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic             rd_lim;
        logic [5:0][12:0] lim;
        logic             src_sel;
        logic             pin_sel;
        logic [5:0]       flags;
        logic [5:0]       ist;
        logic [5:0]       imask;
    } mtm_state_t;

    // State after reset: upper limits all ones, lower limits zero
    function automatic mtm_state_t mtm_rst_state();
        mtm_state_t s;
        s = '0;
        s.st = MTM_BS_IDLE;
        for (int i = 0; i < MTM_NUM_LIM; i++)
        begin
            s.lim[i] = (i % 2 == 0) ? MTM_UP_RST : MTM_LO_RST;
        end
        return s;
    endfunction

endpackage

// File: logic/mtm_threshold_monitor.sv
// Limit checker for temperature and auxiliary conversion results.
// Assumes results arrive as one-cycle strobes synchronous to ref_clk,
// and that software reaches the limits over AXI4-Lite.

// Summary of operation
// - Temperature upper check runs only while its enable bit 12 is set.
// - Temperature upper limit resets to all ones; result at or above it flags.
// - Temperature lower check runs only while its enable bit 12 is set.
// - Temperature lower limit resets to zero; result at or below it flags.
// - Temperature checks follow the active input, by source select or scan mode.
// - The four aux checks work in auto-scan and non-auto-scan alike.
// - Aux one upper check runs only while its enable bit 12 is set.
// - Aux one upper limit resets to all ones; result at or above it flags.
// - Aux one lower check runs only while its enable bit 12 is set.
// - Aux one lower limit resets to zero; result at or below it flags.
// - Aux two upper check runs only while its enable bit 12 is set.
// - Aux two upper limit resets to all ones; result at or above it flags.
// - Aux two lower check runs only while its enable bit 12 is set.
// - Aux two lower limit resets to zero; result at or below it flags.
// - Read-only upper and lower violation flags show each limit pair's latest checked result, so not the inactive temperature input's.
// - With pin interrupt select set, the pin signals any enabled violation.
module mtm_threshold_monitor
    import mtm_pkg::*;
(
    // Clock and reset
    input  logic                  ref_clk,
    input  logic                  rst,

    // AXI4-Lite write address and data
    input  logic [MTM_ADDR_W-1:0] s_axi_awaddr,
    input  logic                  s_axi_awvalid,
    output logic                  s_axi_awready,
    input  logic [31:0]           s_axi_wdata,
    input  logic [3:0]            s_axi_wstrb,
    input  logic                  s_axi_wvalid,
    output logic                  s_axi_wready,

    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  logic                  s_axi_bready,

    // AXI4-Lite read
    input  logic [MTM_ADDR_W-1:0] s_axi_araddr,
    input  logic                  s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  logic                  s_axi_rready,

    // Conversion results and measurement mode
    input  mtm_result_t           res,
    input  logic                  auto_scan,
    input  logic [3:0]            converter_scan_mode,

    // Flags, interrupt and pin
    output logic [5:0]            violation_flags,
    output logic                  irq,
    output logic                  general_pin_one,
    output logic                  general_pin_one_oe
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Word index falls on one of the six limit registers
    function automatic logic is_lim(input logic [5:0] idx);
        return (idx >= MTM_IDX_TEMP_UP) && (idx <= MTM_IDX_AUX_INPUT_TWO_LO);
    endfunction

    // Limit slot of a word index, 0..5
    function automatic logic [2:0] lim_slot(input logic [5:0] idx);
        logic [5:0] d;
        d = idx - MTM_IDX_TEMP_UP;
        return d[2:0];
    endfunction

    // One enabled comparison; equality counts as a violation both ways
    function automatic logic limit_met(input logic [12:0] lim,
                                       input logic [11:0] v,
                                       input logic        upper);
        logic hit;
        hit = upper ? (v >= lim[11:0]) : (v <= lim[11:0]);
        return lim[MTM_EN_BIT] & hit;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    mtm_state_t state_ff;
    mtm_state_t nxt_state;

    logic       t1_act;
    logic       t2_act;
    logic [2:0] grp_hit;
    logic [5:0] ist_set;
    logic [5:0] ist_clr;
    logic [5:0] flags_rev;
    logic [5:0] rd_idx;
    logic [5:0] wr_idx;
    logic [2:0] rd_slot;
    logic [2:0] wr_slot;

    // Configuration word holds the temperature upper flag at bit 8, the top of its flag field
    assign flags_rev = {state_ff.flags[0], state_ff.flags[1], state_ff.flags[2],
                        state_ff.flags[3], state_ff.flags[4], state_ff.flags[5]};

    // ************************************************************
    // Bus handshake outputs
    // ************************************************************

    // Write pieces are taken in either order, one of each at a time
    assign s_axi_awready = (state_ff.st == MTM_BS_IDLE) && !state_ff.aw_got;
    assign s_axi_wready  = (state_ff.st == MTM_BS_IDLE) && !state_ff.w_got;

    // A half-taken write blocks reads so the two never interleave
    assign s_axi_arready = (state_ff.st == MTM_BS_IDLE) && !state_ff.aw_got
                           && !state_ff.w_got;

    assign s_axi_bvalid  = (state_ff.st == MTM_BS_BRESP);
    assign s_axi_bresp   = state_ff.bresp;
    assign s_axi_rvalid  = (state_ff.st == MTM_BS_RRESP);
    assign s_axi_rdata   = state_ff.rdata;
    assign s_axi_rresp   = state_ff.rresp;

    // ************************************************************
    // Block outputs
    // ************************************************************

    // Flags come straight from flops, so reads and pins agree
    assign violation_flags    = state_ff.flags;
    assign irq                = |(state_ff.ist & state_ff.imask);

    // Pin follows the latest flags, not the sticky status
    assign general_pin_one    = state_ff.pin_sel && (|state_ff.flags);
    assign general_pin_one_oe = state_ff.pin_sel;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        ist_set   = '0;
        ist_clr   = '0;
        rd_idx    = s_axi_araddr[7:2];
        wr_idx    = state_ff.waddr[7:2];
        rd_slot   = lim_slot(rd_idx);
        wr_slot   = lim_slot(wr_idx);

        // Active temperature input: source select in auto-scan,
        // scan-mode field otherwise
        t1_act = auto_scan ? !state_ff.src_sel
                           : (converter_scan_mode == MTM_SCAN_TEMP_INPUT_FIRST);
        t2_act = auto_scan ? state_ff.src_sel
                           : (converter_scan_mode == MTM_SCAN_TEMP_INPUT_SECOND);

        // Which limit pair this strobe belongs to; mode does not gate aux
        grp_hit[0] = res.valid && (((res.chan == MTM_CH_TEMP_INPUT_FIRST) && t1_act)
                     || ((res.chan == MTM_CH_TEMP_INPUT_SECOND) && t2_act));
        grp_hit[1] = res.valid && (res.chan == MTM_CH_AUX_INPUT_ONE);
        grp_hit[2] = res.valid && (res.chan == MTM_CH_AUX_INPUT_TWO);

        // Compare once per strobe against the limits held now; a limit
        // written in the same cycle only applies to later results
        for (int g = 0; g < 3; g++)
        begin
            if (grp_hit[g])
            begin
                // Upper check, even slot
                nxt_state.flags[2*g] = limit_met(state_ff.lim[2*g], res.data,
                                                 1'b1);
                // Lower check, odd slot
                nxt_state.flags[2*g+1] = limit_met(state_ff.lim[2*g+1], res.data,
                                                   1'b0);
                ist_set[2*g]   = nxt_state.flags[2*g];
                ist_set[2*g+1] = nxt_state.flags[2*g+1];
            end
        end

        // Bus engine
        case (state_ff.st)
            MTM_BS_IDLE:
            begin
                // Capture address and data as each arrives
                if (s_axi_awvalid && s_axi_awready)
                begin
                    nxt_state.waddr  = s_axi_awaddr;
                    nxt_state.aw_got = 1'b1;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    nxt_state.wdata = s_axi_wdata;
                    nxt_state.wstrb = s_axi_wstrb;
                    nxt_state.w_got = 1'b1;
                end

                if (s_axi_arvalid && s_axi_arready)
                begin
                    // Read: register the word, answer next cycle
                    nxt_state.rdata  = '0;
                    nxt_state.rresp  = MTM_RESP_OKAY;
                    nxt_state.rd_lim = is_lim(rd_idx);
                    if (is_lim(rd_idx))
                    begin
                        // Upper bits stay zero
                        nxt_state.rdata[12:0] = state_ff.lim[rd_slot];
                    end
                    else
                    begin
                        case (rd_idx)
                            MTM_IDX_CFG:
                            begin
                                nxt_state.rdata[MTM_CFG_SRC] = state_ff.src_sel;
                                nxt_state.rdata[MTM_CFG_PIN] = state_ff.pin_sel;
                                nxt_state.rdata[MTM_CFG_FLG_HI:MTM_CFG_FLG_LO] =
                                    flags_rev;
                            end
                            MTM_IDX_IST:
                            begin
                                nxt_state.rdata[5:0] = state_ff.ist;
                            end
                            MTM_IDX_IMASK:
                            begin
                                nxt_state.rdata[5:0] = state_ff.imask;
                            end
                            default:
                            begin
                                nxt_state.rresp = MTM_RESP_SLV;
                            end
                        endcase
                    end
                    nxt_state.st = MTM_BS_RRESP;
                end
                else if (state_ff.aw_got && state_ff.w_got)
                begin
                    // Write: both pieces held, commit then answer
                    nxt_state.bresp  = MTM_RESP_OKAY;
                    nxt_state.aw_got = 1'b0;
                    nxt_state.w_got  = 1'b0;
                    if (is_lim(wr_idx))
                    begin
                        // Only 13 bits are stored, the rest is dropped
                        if (state_ff.wstrb[0])
                        begin
                            nxt_state.lim[wr_slot][7:0] = state_ff.wdata[7:0];
                        end
                        if (state_ff.wstrb[1])
                        begin
                            nxt_state.lim[wr_slot][12:8] = state_ff.wdata[12:8];
                        end
                    end
                    else
                    begin
                        case (wr_idx)
                            MTM_IDX_CFG:
                            begin
                                // Flag bits here are read-only
                                if (state_ff.wstrb[1])
                                begin
                                    nxt_state.src_sel = state_ff.wdata[MTM_CFG_SRC];
                                    nxt_state.pin_sel = state_ff.wdata[MTM_CFG_PIN];
                                end
                            end
                            MTM_IDX_IST:
                            begin
                                if (state_ff.wstrb[0])
                                begin
                                    ist_clr = state_ff.wdata[5:0];
                                end
                            end
                            MTM_IDX_IMASK:
                            begin
                                if (state_ff.wstrb[0])
                                begin
                                    nxt_state.imask = state_ff.wdata[5:0];
                                end
                            end
                            default:
                            begin
                                nxt_state.bresp = MTM_RESP_SLV;
                            end
                        endcase
                    end
                    nxt_state.st = MTM_BS_BRESP;
                end
            end
            MTM_BS_BRESP:
            begin
                if (s_axi_bready)
                begin
                    nxt_state.st = MTM_BS_IDLE;
                end
            end
            MTM_BS_RRESP:
            begin
                if (s_axi_rready)
                begin
                    nxt_state.st = MTM_BS_IDLE;
                end
            end
            default:
            begin
                nxt_state.st = MTM_BS_IDLE;
            end
        endcase

        // Sticky status: a new event beats a clear in the same cycle
        nxt_state.ist = (state_ff.ist & ~ist_clr) | ist_set;
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Synchronous reset loads the documented limit defaults
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_ff <= mtm_rst_state();
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    temp_up_off_a: assert property (
        grp_hit[0] && !state_ff.lim[0][12] |=> !state_ff.flags[0])
        else $error("temperature upper flag set while disabled");

    temp_up_hit_a: assert property (
        grp_hit[0] && state_ff.lim[0][12] && res.data >= state_ff.lim[0][11:0]
        |=> state_ff.flags[0] && state_ff.ist[0])
        else $error("temperature upper violation missed");

    temp_lo_off_a: assert property (
        grp_hit[0] && !state_ff.lim[1][12] |=> !state_ff.flags[1])
        else $error("temperature lower flag set while disabled");

    temp_lo_hit_a: assert property (
        grp_hit[0] && state_ff.lim[1][12] && res.data <= state_ff.lim[1][11:0]
        |=> state_ff.flags[1] && state_ff.ist[1])
        else $error("temperature lower violation missed");

    temp_src_a: assert property (
        auto_scan && res.valid && res.chan == MTM_CH_TEMP_INPUT_SECOND && !state_ff.src_sel
        |=> $stable(state_ff.flags[1:0]))
        else $error("inactive temperature input changed flags");

    aux_both_modes_a: assert property (
        res.valid && res.chan == MTM_CH_AUX_INPUT_TWO && state_ff.lim[5][12]
        && res.data <= state_ff.lim[5][11:0] |=> state_ff.ist[5])
        else $error("aux two lower event lost");

    aux_input_one_up_off_a: assert property (
        grp_hit[1] && !state_ff.lim[2][12] |=> !state_ff.flags[2])
        else $error("aux one upper flag set while disabled");

    aux_input_one_up_hit_a: assert property (
        grp_hit[1] && state_ff.lim[2][12] && res.data >= state_ff.lim[2][11:0]
        |=> state_ff.flags[2])
        else $error("aux one upper violation missed");

    aux_input_one_lo_off_a: assert property (
        grp_hit[1] && !state_ff.lim[3][12] |=> !state_ff.flags[3])
        else $error("aux one lower flag set while disabled");

    aux_input_one_lo_hit_a: assert property (
        grp_hit[1] && state_ff.lim[3][12] && res.data <= state_ff.lim[3][11:0]
        |=> state_ff.flags[3])
        else $error("aux one lower violation missed");

    aux_input_two_up_off_a: assert property (
        grp_hit[2] && !state_ff.lim[4][12] |=> !state_ff.flags[4])
        else $error("aux two upper flag set while disabled");

    aux_input_two_up_hit_a: assert property (
        grp_hit[2] && state_ff.lim[4][12] && res.data >= state_ff.lim[4][11:0]
        |=> state_ff.flags[4])
        else $error("aux two upper violation missed");

    aux_input_two_lo_off_a: assert property (
        grp_hit[2] && !state_ff.lim[5][12] |=> !state_ff.flags[5])
        else $error("aux two lower flag set while disabled");

    aux_input_two_lo_hit_a: assert property (
        grp_hit[2] && state_ff.lim[5][12] && res.data <= state_ff.lim[5][11:0]
        |=> state_ff.flags[5])
        else $error("aux two lower violation missed");

    flag_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == MTM_IDX_CFG
        |=> s_axi_rvalid && s_axi_rdata[8:3] == $past(flags_rev))
        else $error("configuration read shows wrong flags");

    pin_signal_a: assert property (
        state_ff.pin_sel && grp_hit[1] && state_ff.lim[2][12]
        && res.data >= state_ff.lim[2][11:0] |=> general_pin_one && general_pin_one_oe)
        else $error("pin did not signal a violation");

    flags_hold_a: assert property (
        !res.valid |=> $stable(state_ff.flags))
        else $error("flags changed without a result");

    lim_upper_zero_a: assert property (
        s_axi_rvalid && state_ff.rd_lim |-> s_axi_rdata[31:13] == '0)
        else $error("limit upper bits not zero");

    // Main scenarios
    auto_temp_c: cover property (auto_scan && grp_hit[0] ##1 state_ff.flags[0]);
    manual_aux_c: cover property (!auto_scan && grp_hit[1] ##1 state_ff.flags[3]);
    write_done_c: cover property (s_axi_bvalid && s_axi_bready);
    irq_high_c: cover property (!irq ##1 irq);

endmodule // mtm_threshold_monitor

// File: test/mtm_threshold_monitor_tb_top.sv
// Self-checking bench for the measurement threshold monitor.
// Assumes the package and design under logic/ are compiled first.
module mtm_threshold_monitor_tb_top
    import mtm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Signals
    // ****
    logic        ref_clk = 0, rst = 1, auto_scan = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, general_pin_one, oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  scan = 0;
    logic [5:0]  violation_flags;
    mtm_result_t res = '0;
    int          errors = 0, num_checks = 0, cyc = 0;
    // Limits with check enabled; the first also sets bits that must not stick
    logic [31:0] lv [6] = '{32'hffff_f800, 32'h1100, 32'h1a00, 32'h1200, 32'h1c00, 32'h1300};
    // Rows: channel, result code, flags expected afterwards
    logic [19:0] rows [9] = '{{2'h0, 12'h800, 6'h01}, {2'h0, 12'h7ff, 6'h00},
        {2'h0, 12'h100, 6'h02}, {2'h1, 12'h900, 6'h02}, {2'h2, 12'ha00, 6'h06},
        {2'h2, 12'h200, 6'h0a}, {2'h3, 12'hc00, 6'h1a}, {2'h3, 12'h300, 6'h2a},
        {2'h3, 12'h301, 6'h0a}};

    mtm_threshold_monitor dut_u (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .res,
        .auto_scan, .converter_scan_mode(scan), .violation_flags, .irq, .general_pin_one,
        .general_pin_one_oe(oe));

    // Clock and hang guard; tests need under a hundred cycles
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            results();
        end
    end
    // ****
    // Tasks; each but chk is entered just after a rising edge
    // ****
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // Handshakes are judged at the falling edge, so the rising edge never races
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic a, w, b;
        a = 1;
        w = 1;
        b = 0;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (a | w)
        begin
            @(negedge ref_clk) a = a & !s_axi_awready;
            w = w & !s_axi_wready;
            @(posedge ref_clk) s_axi_awvalid <= a;
            s_axi_wvalid <= w;
        end
        s_axi_bready <= 1;
        while (!b)
        begin
            @(negedge ref_clk) b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge ref_clk);
        end
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [5:0] i, output logic [31:0] d);
        logic g;
        g = 0;
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1;
        while (!g)
        begin
            @(negedge ref_clk) g = s_axi_arready;
            @(posedge ref_clk);
        end
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        g = 0;
        while (!g)
        begin
            @(negedge ref_clk) g = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge ref_clk);
        end
        s_axi_rready <= 0;
    endtask

    // One result strobe, then the flags a cycle later
    task automatic put(input logic [1:0] c, input logic [11:0] v, input logic [5:0] f);
        res <= {1'b1, c, v};
        @(posedge ref_clk) res.valid <= 0;
        @(negedge ref_clk) chk("flags", violation_flags, f);
        @(posedge ref_clk);
    endtask

    task automatic results();
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****
    // Sequence: reset values, table of results, then awkward cases
    // ****
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        rd(MTM_IDX_TEMP_UP, rd_v);
        chk("up_rst", rd_v, 32'h0fff);
        rd(MTM_IDX_AUX_INPUT_ONE_LO, rd_v);
        chk("lo_rst", rd_v, 32'h0);
        for (int k = 0; k < 6; k++)
            wr(MTM_IDX_TEMP_UP + 6'(k), lv[k]);
        chk("wr_resp", {30'h0, resp}, 32'h0);
        rd(MTM_IDX_TEMP_UP, rd_v);
        chk("up_wr", rd_v, 32'h1800);
        for (int k = 0; k < 9; k++)
            put(rows[k][19:18], rows[k][17:6], rows[k][5:0]);
        wr(MTM_IDX_IMASK, 32'h04);
        @(negedge ref_clk) chk("irq_on", irq, 1);
        @(posedge ref_clk) wr(MTM_IDX_IST, 32'h04);
        @(negedge ref_clk) chk("irq_clr", irq, 0);
        @(posedge ref_clk) put(2'h2, 12'ha00, 6'h06);
        @(negedge ref_clk) chk("irq_again", irq, 1);
        // Non-auto-scan, second temperature input active
        @(posedge ref_clk) auto_scan <= 0;
        scan <= MTM_SCAN_TEMP_INPUT_SECOND;
        put(2'h1, 12'h800, 6'h05);
        put(2'h0, 12'h800, 6'h05);
        wr(MTM_IDX_TEMP_UP, 32'h0800);
        put(2'h1, 12'hfff, 6'h04);
        wr(MTM_IDX_CFG, 32'h0200);
        @(negedge ref_clk) chk("pin", {general_pin_one, oe}, 2'h3);
        @(posedge ref_clk) rd(MTM_IDX_CFG, rd_v);
        chk("cfg_rd", rd_v, 32'h0240);
        rd(6'h3f, rd_v);
        chk("unmapped", rd_v, 32'h0);
        chk("unmapped_resp", {30'h0, resp}, 32'h2);
        results();
    end
endmodule // mtm_threshold_monitor_tb_top
